// ===== core/tpa_pkg.sv
// package for the tu4 pointer alarm status register bank
package tpa_pkg;
  localparam int          NGRP          = 7;
  localparam logic [11:0] ALARM_BASE    = 12'h771;
  localparam logic [11:0] ALARM_STRIDE  = 12'h002;
  localparam logic [11:0] PLOSS_IRQ_OFF = 12'h77E;
  localparam logic [11:0] PALRM_IRQ_OFF = 12'h77F;
  localparam logic [11:0] SIZE_CFG_OFF  = 12'h780;
  localparam logic [11:0] CTRL_OFF      = 12'h781;
  localparam int B_RELAY  = 0;
  localparam int B_PATH_ALARM_STATE   = 1;
  localparam int B_PEE    = 2;
  localparam int B_ESE    = 3;
  localparam int B_PJE    = 4;
  localparam int B_NJE    = 5;
  localparam int B_SS0    = 6;
  localparam int B_SS1    = 7;
  localparam int B_RSVD   = 7;
  localparam int B_SMALL_TRIBUTARY_SIZE_SELECT   = 6;
  localparam int B_ALARM_IRQ_ENABLE = 0;
  localparam int B_MONITOR_STREAM_SELECT  = 1;
  localparam logic [1:0] AIS_COUNT = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] CFG_RESET   = 8'hC0;
  typedef struct packed {
    logic       ais_ind;
    logic       lop;
    logic       es_err;
    logic       in_pje;
    logic       in_nje;
    logic       out_pje;
    logic       out_nje;
    logic [1:0] ss;
  } tpa_trib_t;
endpackage : tpa_pkg

// ===== core/tpa_top.sv
// tu4 pointer alarm status bank with axi4-lite slave, per tug2 group
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - size bit read-only here, mirrors tu1 size written for group; 1 = four tu-11
// - reserved bit reads back tu1 value; software keeps it at one
// - with tu-12 size, the group's tu4 alarm register has no effect
// - relay bit set: ais on one indication; clear: three consecutive
// - read-only bit shows current tu4 path ais state
// - pointer event enable gates fifo error and justification interrupts
// - monitor select 1 watches incoming justifications, 0 outgoing
// - elastic store flag sets on fifo error, clears on read, always pollable
// - positive justification flag sets on event, clears on read
// - negative justification flag sets on event, clears on read
// - v1 size bits shown raw; software de-bounces them
// - pointer loss irq bits set on loss and regain, clear on read
// - pointer loss irq bit reads zero while group is tu-12
// - path ais irq bits set on entry and exit, clear on read
// - path ais irq bit reads zero while group is tu-12
// - alarm enable gates loss-of-pointer and ais change interrupts
module tpa_top #(
  parameter int NGRP = tpa_pkg::NGRP
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       clk_en,
  input  wire tpa_pkg::tpa_trib_t [NGRP-1:0] trib,
  input  wire logic [NGRP-1:0]            tu1_size_sel,
  input  wire logic [NGRP-1:0]            tu1_rsvd,
  input  wire logic [12:0]                s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [12:0]                s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output logic                            irq
);

  // byte address to word index; indices up to 0x7ff need a 13-bit byte address
  function automatic logic [10:0] widx(input logic [12:0] a);
    widx = a[12:2];
  endfunction : widx

  function automatic int alarm_grp(input logic [11:0] idx);
    int g;
    alarm_grp = -1;
    for (g = 0; g < NGRP; g++)
    begin
      if (idx == tpa_pkg::ALARM_BASE + 12'(g) * tpa_pkg::ALARM_STRIDE)
      begin
        alarm_grp = g;
      end
    end
  endfunction : alarm_grp

  // axi write side state
  logic              aw_have_r, aw_have_nxt;
  logic              w_have_r, w_have_nxt;
  logic [12:0]       aw_addr_r, aw_addr_nxt;
  logic [7:0]        w_data_r, w_data_nxt;
  logic              w_lane0_r, w_lane0_nxt;
  logic              bvalid_r, bvalid_nxt;
  logic [1:0]        bresp_r, bresp_nxt;
  // axi read side state
  logic              rvalid_r, rvalid_nxt;
  logic [31:0]       rdata_r, rdata_nxt;
  logic [1:0]        rresp_r, rresp_nxt;
  // configuration
  logic [NGRP-1:0]   relay_r, relay_nxt;
  logic [NGRP-1:0]   pee_r, pee_nxt;
  logic [NGRP-1:0]   alarm_irq_enable_r, alarm_irq_enable_nxt;
  logic [NGRP-1:0]   monitor_stream_select_r, monitor_stream_select_nxt;
  // status
  logic [NGRP-1:0]   ais_state_r, ais_state_nxt;
  logic [1:0]        ais_cnt_r [NGRP], ais_cnt_nxt [NGRP];
  logic [NGRP-1:0]   lop_d_r, lop_d_nxt;
  logic [NGRP-1:0]   ese_r, ese_nxt;
  logic [NGRP-1:0]   pje_r, pje_nxt;
  logic [NGRP-1:0]   nje_r, nje_nxt;
  logic [NGRP-1:0]   lopi_r, lopi_nxt;
  logic [NGRP-1:0]   aisi_r, aisi_nxt;
  logic              irq_r, irq_nxt;

  logic              wr_go;
  logic              rd_go;
  logic [11:0]       w_idx;
  logic [11:0]       r_idx;
  logic [7:0]        rd_byte;
  logic              rd_hit;
  int                rg;
  int                wg;

  assign s_axi_awready = clk_en & ~aw_have_r & ~bvalid_r;
  assign s_axi_wready  = clk_en & ~w_have_r & ~bvalid_r;
  assign s_axi_arready = clk_en & ~rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign irq           = irq_r;

  assign wr_go = aw_have_r & w_have_r & ~bvalid_r;
  assign rd_go = s_axi_arvalid & s_axi_arready;
  assign w_idx = {1'h0, widx(aw_addr_r)};
  assign r_idx = {1'h0, widx(s_axi_araddr)};
  assign wg    = alarm_grp(w_idx);
  assign rg    = alarm_grp(r_idx);

  // read mux, evaluated in the cycle the address is taken
  always_comb
  begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    if (rg >= 0)
    begin
      rd_byte[tpa_pkg::B_RELAY] = relay_r[rg];
      rd_byte[tpa_pkg::B_PATH_ALARM_STATE]  = ais_state_r[rg];
      rd_byte[tpa_pkg::B_PEE]   = pee_r[rg];
      rd_byte[tpa_pkg::B_ESE]   = ese_r[rg];
      rd_byte[tpa_pkg::B_PJE]   = pje_r[rg];
      rd_byte[tpa_pkg::B_NJE]   = nje_r[rg];
      rd_byte[tpa_pkg::B_SS1:tpa_pkg::B_SS0] = trib[rg].ss;
    end
    else if (r_idx == tpa_pkg::PLOSS_IRQ_OFF)
    begin
      rd_byte[NGRP-1:0] = lopi_r & tu1_size_sel;
    end
    else if (r_idx == tpa_pkg::PALRM_IRQ_OFF)
    begin
      rd_byte[NGRP-1:0] = aisi_r & tu1_size_sel;
    end
    else if (r_idx == tpa_pkg::SIZE_CFG_OFF)
    begin
      // size and reserved bits are views of the tu1 register, per group
      rd_byte[NGRP-1:0] = tu1_size_sel;
    end
    else if (r_idx == tpa_pkg::SIZE_CFG_OFF + 12'h010)
    begin
      rd_byte[NGRP-1:0] = tu1_rsvd;
    end
    else if (r_idx == tpa_pkg::CTRL_OFF)
    begin
      rd_byte[NGRP-1:0] = alarm_irq_enable_r;
    end
    else if (r_idx == tpa_pkg::CTRL_OFF + 12'h010)
    begin
      rd_byte[NGRP-1:0] = monitor_stream_select_r;
    end
    else
    begin
      rd_hit = 1'b0;
    end
  end

  always_comb
  begin
    aw_have_nxt = aw_have_r;
    w_have_nxt  = w_have_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt  = w_data_r;
    w_lane0_nxt = w_lane0_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    relay_nxt   = relay_r;
    pee_nxt     = pee_r;
    alarm_irq_enable_nxt  = alarm_irq_enable_r;
    monitor_stream_select_nxt   = monitor_stream_select_r;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_nxt  = 1'b1;
      w_data_nxt  = s_axi_wdata[7:0];
      w_lane0_nxt = s_axi_wstrb[0];
    end
    if (bvalid_r && s_axi_bready)
    begin
      bvalid_nxt = 1'b0;
    end
    if (wr_go)
    begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = tpa_pkg::RESP_OKAY;
      if (wg >= 0)
      begin
        if (w_lane0_r)
        begin
          relay_nxt[wg] = w_data_r[tpa_pkg::B_RELAY];
          pee_nxt[wg]   = w_data_r[tpa_pkg::B_PEE];
        end
      end
      else if (w_idx == tpa_pkg::CTRL_OFF)
      begin
        if (w_lane0_r)
        begin
          alarm_irq_enable_nxt = w_data_r[NGRP-1:0];
        end
      end
      else if (w_idx == tpa_pkg::CTRL_OFF + 12'h010)
      begin
        if (w_lane0_r)
        begin
          monitor_stream_select_nxt = w_data_r[NGRP-1:0];
        end
      end
      else if (w_idx == tpa_pkg::PLOSS_IRQ_OFF || w_idx == tpa_pkg::PALRM_IRQ_OFF ||
               w_idx == tpa_pkg::SIZE_CFG_OFF || w_idx == tpa_pkg::SIZE_CFG_OFF + 12'h010)
      begin
        bresp_nxt = tpa_pkg::RESP_OKAY;
      end
      else
      begin
        bresp_nxt = tpa_pkg::RESP_SLVERR;
      end
    end
    if (rvalid_r && s_axi_rready)
    begin
      rvalid_nxt = 1'b0;
    end
    if (rd_go)
    begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = {24'h000000, rd_byte};
      rresp_nxt  = rd_hit ? tpa_pkg::RESP_OKAY : tpa_pkg::RESP_SLVERR;
    end
  end

  // alarm and event logic; a set in the same cycle as a read-clear wins
  always_comb
  begin
    logic rd_alarm;
    logic pj;
    logic nj;
    rd_alarm      = 1'b0;
    pj            = 1'b0;
    nj            = 1'b0;
    ais_state_nxt = ais_state_r;
    lop_d_nxt     = lop_d_r;
    ese_nxt       = ese_r;
    pje_nxt       = pje_r;
    nje_nxt       = nje_r;
    lopi_nxt      = lopi_r;
    aisi_nxt      = aisi_r;
    irq_nxt       = 1'b0;
    for (int g = 0; g < NGRP; g++)
    begin
      ais_cnt_nxt[g] = ais_cnt_r[g];
      rd_alarm = rd_go && (rg == g);
      if (rd_alarm)
      begin
        ese_nxt[g] = 1'b0;
        pje_nxt[g] = 1'b0;
        nje_nxt[g] = 1'b0;
      end
      if (rd_go && r_idx == tpa_pkg::PLOSS_IRQ_OFF)
      begin
        lopi_nxt[g] = 1'b0;
      end
      if (rd_go && r_idx == tpa_pkg::PALRM_IRQ_OFF)
      begin
        aisi_nxt[g] = 1'b0;
      end
      // a tu-12 group has no fourth slot, so only the lop delay tracks here; ais state, counter and irq bits are held clear
      if (tu1_size_sel[g])
      begin
        if (trib[g].ais_ind)
        begin
          if (ais_cnt_r[g] != tpa_pkg::AIS_COUNT)
          begin
            ais_cnt_nxt[g] = ais_cnt_r[g] + 2'h1;
          end
          if (relay_r[g] || ais_cnt_r[g] == tpa_pkg::AIS_COUNT - 2'h1)
          begin
            ais_state_nxt[g] = 1'b1;
          end
        end
        else
        begin
          ais_cnt_nxt[g]   = 2'h0;
          ais_state_nxt[g] = 1'b0;
        end
        pj = monitor_stream_select_r[g] ? trib[g].in_pje : trib[g].out_pje;
        nj = monitor_stream_select_r[g] ? trib[g].in_nje : trib[g].out_nje;
        if (trib[g].es_err)
        begin
          ese_nxt[g] = 1'b1;
        end
        if (pj)
        begin
          pje_nxt[g] = 1'b1;
        end
        if (nj)
        begin
          nje_nxt[g] = 1'b1;
        end
        lop_d_nxt[g] = trib[g].lop;
        if (trib[g].lop != lop_d_r[g])
        begin
          lopi_nxt[g] = 1'b1;
        end
        if (ais_state_nxt[g] != ais_state_r[g])
        begin
          aisi_nxt[g] = 1'b1;
        end
      end
      else
      begin
        ais_cnt_nxt[g]   = 2'h0;
        ais_state_nxt[g] = 1'b0;
        lop_d_nxt[g]     = trib[g].lop;
        lopi_nxt[g]      = 1'b0;
        aisi_nxt[g]      = 1'b0;
      end
      if (pee_r[g] && (ese_r[g] || pje_r[g] || nje_r[g]))
      begin
        irq_nxt = 1'b1;
      end
      if (alarm_irq_enable_r[g] && (lopi_r[g] || aisi_r[g]))
      begin
        irq_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_have_r   <= 1'b0;
      w_have_r    <= 1'b0;
      aw_addr_r   <= 13'h0000;
      w_data_r    <= 8'h00;
      w_lane0_r   <= 1'b0;
      bvalid_r    <= 1'b0;
      bresp_r     <= tpa_pkg::RESP_OKAY;
      rvalid_r    <= 1'b0;
      rdata_r     <= 32'h00000000;
      rresp_r     <= tpa_pkg::RESP_OKAY;
      relay_r     <= '0;
      pee_r       <= '0;
      alarm_irq_enable_r    <= '0;
      monitor_stream_select_r     <= '0;
      ais_state_r <= '0;
      lop_d_r     <= '0;
      ese_r       <= '0;
      pje_r       <= '0;
      nje_r       <= '0;
      lopi_r      <= '0;
      aisi_r      <= '0;
      irq_r       <= 1'b0;
      for (int g = 0; g < NGRP; g++)
      begin
        ais_cnt_r[g] <= 2'h0;
      end
    end
    else if (clk_en)
    begin
      aw_have_r   <= aw_have_nxt;
      w_have_r    <= w_have_nxt;
      aw_addr_r   <= aw_addr_nxt;
      w_data_r    <= w_data_nxt;
      w_lane0_r   <= w_lane0_nxt;
      bvalid_r    <= bvalid_nxt;
      bresp_r     <= bresp_nxt;
      rvalid_r    <= rvalid_nxt;
      rdata_r     <= rdata_nxt;
      rresp_r     <= rresp_nxt;
      relay_r     <= relay_nxt;
      pee_r       <= pee_nxt;
      alarm_irq_enable_r    <= alarm_irq_enable_nxt;
      monitor_stream_select_r     <= monitor_stream_select_nxt;
      ais_state_r <= ais_state_nxt;
      lop_d_r     <= lop_d_nxt;
      ese_r       <= ese_nxt;
      pje_r       <= pje_nxt;
      nje_r       <= nje_nxt;
      lopi_r      <= lopi_nxt;
      aisi_r      <= aisi_nxt;
      irq_r       <= irq_nxt;
      for (int g = 0; g < NGRP; g++)
      begin
        ais_cnt_r[g] <= ais_cnt_nxt[g];
      end
    end
  end

endmodule : tpa_top
`default_nettype wire

// ===== dv/test_tpa_top.sv
// self-checking bench for the tu4 pointer alarm status bank
`timescale 1ns/1ns
`default_nettype none
module test_tpa_top;
  localparam int N = tpa_pkg::NGRP;
  logic                 clk, rst_n, ev_valid, irq;
  logic [2:0]           ev_grp;
  tpa_pkg::tpa_trib_t   ev_val, lv[N];
  tpa_pkg::tpa_trib_t [N-1:0] trib;
  logic [N-1:0]         size_sel, rsvd;
  logic [12:0]          awaddr, araddr;
  logic                 awvalid, wvalid, bready, arvalid, rready;
  logic                 awready, wready, bvalid, arready, rvalid;
  logic [31:0]          wdata, rdata;
  logic [1:0]           bresp, rresp;
  int                   bad_count, checks, lfsr, cfg[N], flg[N], lop_i, ais_i, alm, mon;
  tpa_trib_src u_src (.clk, .rst_n, .ev_valid, .ev_grp, .ev_val, .trib);
  tpa_top dut (.clk, .rst_n, .clk_en(1'h1), .trib, .tu1_size_sel(size_sel),
    .tu1_rsvd(rsvd), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq);
  function automatic int nxt(input int s);
    return {15'h0, s[15:0], s[16] ^ s[13]};
  endfunction : nxt
  function automatic logic irq_exp();
    logic e;
    e = 1'h0;
    for (int g = 0; g < N; g++)
      e |= size_sel[g] && ((flg[g] != 0 && cfg[g][2]) || (((lop_i | ais_i) & alm) >> g & 1));
    return e;
  endfunction : irq_exp
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] idx, input logic [7:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= {idx[10:0], 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
    end
    while (bvalid !== 1'h1);
    bready <= 1'h0;
    r = bresp;
  endtask : wr
  task automatic rc(input logic [11:0] idx, input logic [31:0] exp);
    @(posedge clk);
    araddr <= {idx[10:0], 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'h0;
    end
    while (rvalid !== 1'h1);
    rready <= 1'h0;
    chk(rdata, exp);
    chk(rresp, (idx == 12'h7A0) ? tpa_pkg::RESP_SLVERR : tpa_pkg::RESP_OKAY);
  endtask : rc
  task automatic ev(input int g, input tpa_pkg::tpa_trib_t v, input int w);
    @(posedge clk);
    ev_valid <= 1'h1;
    ev_grp <= g[2:0];
    ev_val <= v;
    @(posedge clk);
    ev_valid <= 1'h0;
    repeat (w) @(posedge clk);
  endtask : ev
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #200000;
    bad_count++;
    report_and_stop();
  end
  initial
  begin : main
    logic [1:0] r;
    logic [11:0] st;
    tpa_pkg::tpa_trib_t v;
    int w, p, q;
    {ev_valid, ev_grp, ev_val, awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready, rst_n} = '0;
    size_sel = 7'h3F;
    rsvd = 7'h7F;
    lfsr = 76425;
    {lop_i, ais_i} = '0;
    for (int g = 0; g < N; g++)
      {cfg[g], flg[g], lv[g]} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    rc(tpa_pkg::SIZE_CFG_OFF, {25'h0, size_sel});
    rc(12'h790, {25'h0, rsvd});
    rc(tpa_pkg::ALARM_BASE, 32'h0);
    rc(tpa_pkg::PLOSS_IRQ_OFF, 32'h0);
    rc(tpa_pkg::PALRM_IRQ_OFF, 32'h0);
    rc(12'h7A0, 32'h0);
    wr(12'h7A0, 8'hFF, r);
    chk(r, tpa_pkg::RESP_SLVERR);
    lfsr = nxt(lfsr);
    alm = lfsr & 8'h7F;
    mon = (lfsr >> 7) & 8'h7F;
    wr(tpa_pkg::CTRL_OFF, alm[7:0], r);
    wr(12'h791, mon[7:0], r);
    rc(tpa_pkg::CTRL_OFF, alm);
    rc(12'h791, mon);
    $display("reset and map test done");
    for (int g = 0; g < N; g++)
    begin
      st = 12'(tpa_pkg::ALARM_BASE + tpa_pkg::ALARM_STRIDE * g);
      for (int k = 0; k < 3; k++)
      begin
        lfsr = nxt(lfsr);
        if (k == 0)
        begin
          wr(st, lfsr[7:0], r);
          cfg[g] = size_sel[g] ? lfsr & 5 : 0;
        end
        v = lfsr[16:8];
        w = lfsr[5:4];
        ev(g, v, w);
        ev(g, tpa_pkg::tpa_trib_t'(v & 9'h083), 2);
        if (size_sel[g])
        begin
          p = mon[g] ? v.in_pje : v.out_pje;
          q = mon[g] ? v.in_nje : v.out_nje;
          flg[g] = flg[g] | {26'h0, q[0], p[0], v.es_err, 3'h0};
          if (v.lop != lv[g].lop)
            lop_i |= 1 << g;
          if (v.ais_ind && w + 2 >= (cfg[g][0] ? 1 : 3))
            ais_i |= 1 << g;
        end
        lv[g] = v;
        @(negedge clk);
        chk(irq, irq_exp());
        if (size_sel[g])
          rc(st, {24'h0, lv[g].ss, 6'(flg[g] | cfg[g])});
        flg[g] = 0;
        rc(tpa_pkg::PLOSS_IRQ_OFF, lop_i);
        lop_i = 0;
        rc(tpa_pkg::PALRM_IRQ_OFF, ais_i);
        ais_i = 0;
        @(negedge clk);
        chk(irq, 1'h0);
      end
    end
    $display("event and flag test done");
    // keep only levels so no stale event pulse is replayed
    v = tpa_pkg::tpa_trib_t'(lv[0] & 9'h083);
    v.ais_ind = 1'h1;
    ev(0, v, 3);
    rc(tpa_pkg::ALARM_BASE, {24'h0, v.ss, 6'(cfg[0] | 2)});
    v.ais_ind = 1'h0;
    ev(0, v, 2);
    rc(tpa_pkg::PALRM_IRQ_OFF, 32'h1);
    $display("ais state test done");
    report_and_stop();
  end
endmodule : test_tpa_top
`default_nettype wire

// ===== dv/tpa_properties.sv
// bus and status properties for the tu4 pointer alarm status bank
`timescale 1ns/1ns
`default_nettype none
module tpa_properties #(
  parameter int NGRP = tpa_pkg::NGRP
) (
  input wire logic                          clk,
  input wire logic                          rst_n,
  input wire logic                          clk_en,
  input wire tpa_pkg::tpa_trib_t [NGRP-1:0] trib,
  input wire logic [NGRP-1:0]               tu1_size_sel,
  input wire logic [NGRP-1:0]               tu1_rsvd,
  input wire logic [12:0]                   s_axi_araddr,
  input wire logic                          s_axi_arvalid,
  input wire logic                          s_axi_arready,
  input wire logic [31:0]                   s_axi_rdata,
  input wire logic [1:0]                    s_axi_rresp,
  input wire logic                          s_axi_rvalid,
  input wire logic                          s_axi_rready,
  input wire logic                          s_axi_awvalid,
  input wire logic                          s_axi_awready,
  input wire logic                          s_axi_wvalid,
  input wire logic                          s_axi_wready,
  input wire logic                          s_axi_bvalid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // byte address is four times the word index
  localparam logic [12:0] A_ST0 = {tpa_pkg::ALARM_BASE[10:0], 2'h0};
  localparam logic [12:0] A_LOP = {tpa_pkg::PLOSS_IRQ_OFF[10:0], 2'h0};
  localparam logic [12:0] A_AIS = {tpa_pkg::PALRM_IRQ_OFF[10:0], 2'h0};
  localparam logic [12:0] A_SZ  = {tpa_pkg::SIZE_CFG_OFF[10:0], 2'h0};
  localparam logic [12:0] A_RS  = 13'h1E40;
  localparam logic [12:0] A_UN  = 13'h1E80;
  logic rd_tk;
  logic st0_rd;
  logic ev0;
  logic evt_r;
  logic evt_nxt;
  assign rd_tk  = s_axi_arvalid && s_axi_arready && clk_en;
  assign st0_rd = rd_tk && s_axi_araddr == A_ST0;
  assign ev0    = |{trib[0].es_err, trib[0].in_pje, trib[0].in_nje, trib[0].out_pje,
                    trib[0].out_nje};
  // any group 0 event since the last status read
  always_comb
  begin
    evt_nxt = clk_en ? (ev0 || (evt_r && !st0_rd)) : evt_r;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      evt_r <= 1'h0;
    else
      evt_r <= evt_nxt;
  end
  chk_read_answer: assert property (rd_tk |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  chk_write_answer: assert property (clk_en && s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write not answered");
  chk_size_mirror: assert property (rd_tk && s_axi_araddr == A_SZ |=>
    s_axi_rdata[NGRP-1:0] == tu1_size_sel) else $error("size mirror wrong");
  chk_rsvd_mirror: assert property (rd_tk && s_axi_araddr == A_RS |=>
    s_axi_rdata[NGRP-1:0] == tu1_rsvd) else $error("reserved mirror wrong");
  chk_lop_small_off: assert property (rd_tk && s_axi_araddr == A_LOP |=>
    (s_axi_rdata[NGRP-1:0] & ~tu1_size_sel) == '0) else $error("lop bit of tu12 set");
  chk_ais_small_off: assert property (rd_tk && s_axi_araddr == A_AIS |=>
    (s_axi_rdata[NGRP-1:0] & ~tu1_size_sel) == '0) else $error("ais bit of tu12 set");
  chk_unmapped_read: assert property (rd_tk && s_axi_araddr == A_UN |=>
    s_axi_rresp == tpa_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad unmapped");
  chk_flag_quiet: assert property (st0_rd && !evt_r && !ev0 |=>
    s_axi_rdata[5:3] == 3'h0) else $error("flag set with no event");
  chk_ais_clear: assert property (st0_rd && !$past(trib[0].ais_ind) |=>
    !s_axi_rdata[1]) else $error("ais state held without indication");
endmodule : tpa_properties
bind tpa_top tpa_properties #(.NGRP(NGRP)) u_props (.clk, .rst_n, .clk_en, .trib,
  .tu1_size_sel, .tu1_rsvd, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid);
`default_nettype wire

// ===== dv/tpa_trib_src.sv
// upstream tributary stream model driving the per-group trib inputs
`timescale 1ns/1ns
`default_nettype none
module tpa_trib_src #(
  parameter int NGRP = tpa_pkg::NGRP
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     ev_valid,
  input  wire logic [2:0]               ev_grp,
  input  wire tpa_pkg::tpa_trib_t       ev_val,
  output var tpa_pkg::tpa_trib_t [NGRP-1:0] trib
);
  tpa_pkg::tpa_trib_t [NGRP-1:0] trib_r;
  tpa_pkg::tpa_trib_t [NGRP-1:0] trib_nxt;
  always_comb
  begin
    for (int g = 0; g < NGRP; g++)
    begin
      // events are one-cycle pulses; ais, lop and raw size bits stay as levels
      trib_nxt[g] = tpa_pkg::tpa_trib_t'(trib_r[g] & 9'h183);
    end
    if (ev_valid)
      trib_nxt[ev_grp] = ev_val;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      trib_r <= '0;
    else
      trib_r <= trib_nxt;
  end
  assign trib = trib_r;
endmodule : tpa_trib_src
`default_nettype wire
